/* hw/sirq_shared_map.v */
// routing of on-chip interrupt sources onto the shared interrupt inputs
// Function
// - serial port zero drives input 9, serial port one drives input 10
// - two-wire controllers zero and one drive inputs 11 and 12
// - serial master controller interrupt drives input 13
// - auxiliary processor lock indication drives input 14
// - mailbox soft interrupts zero and one drive inputs 15 and 16
// - serial pin expander interrupts zero to two drive inputs 17 to 19
// - parallel pin controller interrupt drives input 20
// - management masters zero to three drive inputs 21 to 24 in order
// - frame DMA drives input 25, frame analyzer drives input 26
// - memory integrity monitor drives input 29
// - extraction ready drives input 30, injection ready drives input 31
// - PCIe power management interrupt drives input 32
// - fast serializer interrupts fill inputs 47 to 66, one each
// - mid serializer interrupts fill inputs 67 to 79, one each
// - cache ECC fatal fault drives input 145
// - AXI external error toward processor drives input 146
// - PCIe legacy lines reversed: D 147, C 148, B 149, A 150
// - root complex events: system 151, PME 152, AER 153, SII 154, wake 155
// - write to translation register raises message interrupt, no wire used
// - pin-mapped sources drive inputs 0 and 1, input 2 stays reserved
// - watchdog drives input 5, timers zero to two drive inputs 6 to 8
`timescale 1ns/1ps
`default_nettype none
`include "sirq_defines.vh"

module sirq_shared_map #(
    parameter N_TMR = `SIRQ_TMR_HI - `SIRQ_TMR_LO + 1,
    parameter N_SPE = `SIRQ_SPE_HI - `SIRQ_SPE_LO + 1,
    parameter N_MGMT = `SIRQ_MGMT_HI - `SIRQ_MGMT_LO + 1,
    parameter N_CPU = `SIRQ_CPU_HI - `SIRQ_CPU_LO + 1,
    parameter N_FSER = `SIRQ_FSER_HI - `SIRQ_FSER_LO + 1,
    parameter N_MSER = `SIRQ_MSER_HI - `SIRQ_MSER_LO + 1,
    parameter N_PORT = `SIRQ_PORT_HI - `SIRQ_PORT_LO + 1
) (
    input wire clk,
    input wire rst,
    // low-numbered system sources
    input wire pin_mapped_irq_zero,
    input wire pin_mapped_irq_one,
    input wire storage_wake_irq,
    input wire storage_irq,
    input wire watchdog_irq,
    input wire [N_TMR-1:0] timer_irqs,
    // serial and pin peripherals
    input wire serial_port_irq_zero,
    input wire serial_port_irq_one,
    input wire two_wire_ctrl_irq_zero,
    input wire two_wire_ctrl_irq_one,
    input wire serial_master_ctrl_irq,
    input wire aux_processor_lock_irq,
    input wire mailbox_soft_irq_zero,
    input wire mailbox_soft_irq_one,
    input wire [N_SPE-1:0] serial_pin_expander_irqs,
    input wire parallel_pin_irq,
    input wire [N_MGMT-1:0] mgmt_master_irqs,
    // switch core sources
    input wire frame_dma_irq,
    input wire frame_analyzer_irq,
    input wire timestamp_ready_irq,
    input wire time_sync_irq,
    input wire mem_integrity_irq,
    input wire extraction_ready_irq,
    input wire injection_ready_irq,
    input wire pcie_power_mgmt_irq,
    input wire access_list_irq,
    input wire rewriter_irq,
    input wire ddr_ctrl_irq,
    input wire [N_CPU-1:0] cpu_shared_irqs,
    input wire [N_FSER-1:0] fast_serializer_irqs,
    input wire [N_MSER-1:0] mid_serializer_irqs,
    input wire [N_PORT-1:0] port_module_irqs,
    // processor errors
    input wire cache_ecc_fatal_irq,
    input wire bus_external_error_irq,
    // PCIe legacy lines and root complex events
    input wire pcie_legacy_line_a,
    input wire pcie_legacy_line_b,
    input wire pcie_legacy_line_c,
    input wire pcie_legacy_line_d,
    input wire root_complex_system_error,
    input wire root_complex_pme,
    input wire root_complex_adv_error,
    input wire root_complex_sii,
    input wire root_complex_wake,
    // bus master writes toward the message interrupt translation register
    input wire msg_wr_en,
    input wire [`SIRQ_MSG_ADDR_W-1:0] msg_wr_addr,
    input wire [`SIRQ_MSG_DATA_W-1:0] msg_wr_data,
    // shared input vector toward the interrupt controller
    output reg [`SIRQ_SPI_W-1:0] spi_vec_reg,
    // message interrupt event
    output wire msg_irq_valid,
    output wire [`SIRQ_MSG_DATA_W-1:0] msg_irq_id
);

    reg [`SIRQ_SPI_W-1:0] spi_vec_next;

    // slot count of each grouped range, fixed by the numbering
    localparam TMR_SLOTS = `SIRQ_TMR_HI - `SIRQ_TMR_LO + 1;
    localparam SPE_SLOTS = `SIRQ_SPE_HI - `SIRQ_SPE_LO + 1;
    localparam MGMT_SLOTS = `SIRQ_MGMT_HI - `SIRQ_MGMT_LO + 1;
    localparam CPU_SLOTS = `SIRQ_CPU_HI - `SIRQ_CPU_LO + 1;
    localparam FSER_SLOTS = `SIRQ_FSER_HI - `SIRQ_FSER_LO + 1;
    localparam MSER_SLOTS = `SIRQ_MSER_HI - `SIRQ_MSER_LO + 1;
    localparam PORT_SLOTS = `SIRQ_PORT_HI - `SIRQ_PORT_LO + 1;

    // one bit per slot of each grouped range, bit 0 on the lowest slot
    wire [TMR_SLOTS-1:0] tmr_slots;
    wire [SPE_SLOTS-1:0] spe_slots;
    wire [MGMT_SLOTS-1:0] mgmt_slots;
    wire [CPU_SLOTS-1:0] cpu_slots;
    wire [FSER_SLOTS-1:0] fser_slots;
    wire [MSER_SLOTS-1:0] mser_slots;
    wire [PORT_SLOTS-1:0] port_slots;
    genvar gi;

    ////////////////////////////////////////////////////////////////////////
    // grouped sources spread one bit per slot; a build with fewer sources leaves the rest idle
    // general timers
    generate
        for (gi = 0; gi < TMR_SLOTS; gi = gi + 1)
        begin : g_tmr
            if (gi < N_TMR)
            begin : g_src
                assign tmr_slots[gi] = timer_irqs[gi];
            end
            else
            begin : g_idle
                assign tmr_slots[gi] = 1'h0;
            end
        end
    endgenerate

    // serial pin expander
    generate
        for (gi = 0; gi < SPE_SLOTS; gi = gi + 1)
        begin : g_spe
            if (gi < N_SPE)
            begin : g_src
                assign spe_slots[gi] = serial_pin_expander_irqs[gi];
            end
            else
            begin : g_idle
                assign spe_slots[gi] = 1'h0;
            end
        end
    endgenerate

    // management masters
    generate
        for (gi = 0; gi < MGMT_SLOTS; gi = gi + 1)
        begin : g_mgmt
            if (gi < N_MGMT)
            begin : g_src
                assign mgmt_slots[gi] = mgmt_master_irqs[gi];
            end
            else
            begin : g_idle
                assign mgmt_slots[gi] = 1'h0;
            end
        end
    endgenerate

    // shared software interrupts
    generate
        for (gi = 0; gi < CPU_SLOTS; gi = gi + 1)
        begin : g_cpu
            if (gi < N_CPU)
            begin : g_src
                assign cpu_slots[gi] = cpu_shared_irqs[gi];
            end
            else
            begin : g_idle
                assign cpu_slots[gi] = 1'h0;
            end
        end
    endgenerate

    // fast serializer modules
    generate
        for (gi = 0; gi < FSER_SLOTS; gi = gi + 1)
        begin : g_fser
            if (gi < N_FSER)
            begin : g_src
                assign fser_slots[gi] = fast_serializer_irqs[gi];
            end
            else
            begin : g_idle
                assign fser_slots[gi] = 1'h0;
            end
        end
    endgenerate

    // mid serializer modules
    generate
        for (gi = 0; gi < MSER_SLOTS; gi = gi + 1)
        begin : g_mser
            if (gi < N_MSER)
            begin : g_src
                assign mser_slots[gi] = mid_serializer_irqs[gi];
            end
            else
            begin : g_idle
                assign mser_slots[gi] = 1'h0;
            end
        end
    endgenerate

    // port modules
    generate
        for (gi = 0; gi < PORT_SLOTS; gi = gi + 1)
        begin : g_port
            if (gi < N_PORT)
            begin : g_src
                assign port_slots[gi] = port_module_irqs[gi];
            end
            else
            begin : g_idle
                assign port_slots[gi] = 1'h0;
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // source to index mapping, all groups, lowest index first
    always @*
    begin
        // every slot starts inactive so unassigned ones stay low
        spi_vec_next = {`SIRQ_SPI_W{1'h0}};

        // external pin sources, slot 2 left reserved
        spi_vec_next[`SIRQ_PIN0] = pin_mapped_irq_zero;
        spi_vec_next[`SIRQ_PIN1] = pin_mapped_irq_one;
        spi_vec_next[`SIRQ_RSVD] = 1'h0;

        // storage controller pair
        spi_vec_next[`SIRQ_STOR_WAKE] = storage_wake_irq;
        spi_vec_next[`SIRQ_STOR] = storage_irq;

        // watchdog and the general timers
        spi_vec_next[`SIRQ_WDOG] = watchdog_irq;
        spi_vec_next[`SIRQ_TMR_HI:`SIRQ_TMR_LO] = tmr_slots;

        // asynchronous serial ports
        spi_vec_next[`SIRQ_UART0] = serial_port_irq_zero;
        spi_vec_next[`SIRQ_UART1] = serial_port_irq_one;

        // two-wire controllers
        spi_vec_next[`SIRQ_TWC0] = two_wire_ctrl_irq_zero;
        spi_vec_next[`SIRQ_TWC1] = two_wire_ctrl_irq_one;

        // serial master controller
        spi_vec_next[`SIRQ_SMC] = serial_master_ctrl_irq;

        // auxiliary processor lock indication
        spi_vec_next[`SIRQ_AUX_LOCK] = aux_processor_lock_irq;

        // mailbox software interrupts, zero then one
        spi_vec_next[`SIRQ_MBX0] = mailbox_soft_irq_zero;
        spi_vec_next[`SIRQ_MBX1] = mailbox_soft_irq_one;

        // serial pin expander, bit 0 lands on the lowest slot
        spi_vec_next[`SIRQ_SPE_HI:`SIRQ_SPE_LO] = spe_slots;

        // parallel pin controller
        spi_vec_next[`SIRQ_PPIN] = parallel_pin_irq;

        // management masters, bit 0 lands on the lowest slot
        spi_vec_next[`SIRQ_MGMT_HI:`SIRQ_MGMT_LO] = mgmt_slots;

        // frame DMA and analyzer
        spi_vec_next[`SIRQ_FRAME_DMA_IRQ] = frame_dma_irq;
        spi_vec_next[`SIRQ_FANA] = frame_analyzer_irq;

        // timestamp block
        spi_vec_next[`SIRQ_TS_RDY] = timestamp_ready_irq;
        spi_vec_next[`SIRQ_TS_SYNC] = time_sync_irq;

        // memory integrity monitor
        spi_vec_next[`SIRQ_MEMI] = mem_integrity_irq;

        // frame extraction and injection readiness
        spi_vec_next[`SIRQ_XRDY] = extraction_ready_irq;
        spi_vec_next[`SIRQ_IRDY] = injection_ready_irq;

        // PCIe power management
        spi_vec_next[`SIRQ_PCIE_PM] = pcie_power_mgmt_irq;

        // slot 33 has no source and is left at zero
        spi_vec_next[`SIRQ_UNUSED] = 1'h0;

        // remaining switch core blocks
        spi_vec_next[`SIRQ_ACL] = access_list_irq;
        spi_vec_next[`SIRQ_REW] = rewriter_irq;
        spi_vec_next[`SIRQ_DDR] = ddr_ctrl_irq;

        // shared software interrupts
        spi_vec_next[`SIRQ_CPU_HI:`SIRQ_CPU_LO] = cpu_slots;

        // serializer groups, module 0 on the lowest slot of each range
        spi_vec_next[`SIRQ_FSER_HI:`SIRQ_FSER_LO] = fser_slots;
        spi_vec_next[`SIRQ_MSER_HI:`SIRQ_MSER_LO] = mser_slots;

        // port modules
        spi_vec_next[`SIRQ_PORT_HI:`SIRQ_PORT_LO] = port_slots;

        // processor error indications
        spi_vec_next[`SIRQ_ECC] = cache_ecc_fatal_irq;
        spi_vec_next[`SIRQ_AXI_ERR] = bus_external_error_irq;

        // legacy lines run in reverse, D on the lowest slot
        spi_vec_next[`SIRQ_LEG_D] = pcie_legacy_line_d;
        spi_vec_next[`SIRQ_LEG_C] = pcie_legacy_line_c;
        spi_vec_next[`SIRQ_LEG_B] = pcie_legacy_line_b;
        spi_vec_next[`SIRQ_LEG_A] = pcie_legacy_line_a;

        // root complex events
        spi_vec_next[`SIRQ_RC_SYS] = root_complex_system_error;
        spi_vec_next[`SIRQ_RC_PME] = root_complex_pme;
        spi_vec_next[`SIRQ_RC_AER] = root_complex_adv_error;
        spi_vec_next[`SIRQ_RC_SII] = root_complex_sii;
        spi_vec_next[`SIRQ_RC_WAKE] = root_complex_wake;
    end

    ////////////////////////////////////////////////////////////////////////
    // one register stage so every output comes straight from a flop;
    // levels pass through unchanged, one clock late, no sticky behaviour
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            spi_vec_reg <= {`SIRQ_SPI_W{1'h0}};
        end
        else
        begin
            spi_vec_reg <= spi_vec_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // message interrupts travel as writes, never on the shared vector
    sirq_msg_xlate #(
        .AW(`SIRQ_MSG_ADDR_W),
        .DW(`SIRQ_MSG_DATA_W)
    ) u_xlate (
        .clk(clk),
        .rst(rst),
        .wr_en(msg_wr_en),
        .wr_addr(msg_wr_addr),
        .wr_data(msg_wr_data),
        .irq_valid_reg(msg_irq_valid),
        .irq_id_reg(msg_irq_id)
    );

endmodule // sirq_shared_map

`default_nettype wire

/* hw/sirq_defines.vh */
// shared interrupt input numbering and message interrupt constants
`ifndef SIRQ_DEFINES_VH
`define SIRQ_DEFINES_VH

// width of the shared input vector, indices 0 to 155
`define SIRQ_SPI_W 156

// pin-mapped external sources and reserved slot
`define SIRQ_PIN0 0
`define SIRQ_PIN1 1
`define SIRQ_RSVD 2
`define SIRQ_STOR_WAKE 3
`define SIRQ_STOR 4
`define SIRQ_WDOG 5
`define SIRQ_TMR_LO 6
`define SIRQ_TMR_HI 8
`define SIRQ_UART0 9
`define SIRQ_UART1 10
`define SIRQ_TWC0 11
`define SIRQ_TWC1 12
`define SIRQ_SMC 13
`define SIRQ_AUX_LOCK 14
`define SIRQ_MBX0 15
`define SIRQ_MBX1 16
`define SIRQ_SPE_LO 17
`define SIRQ_SPE_HI 19
`define SIRQ_PPIN 20
`define SIRQ_MGMT_LO 21
`define SIRQ_MGMT_HI 24
`define SIRQ_FRAME_DMA_IRQ 25
`define SIRQ_FANA 26
`define SIRQ_TS_RDY 27
`define SIRQ_TS_SYNC 28
`define SIRQ_MEMI 29
`define SIRQ_XRDY 30
`define SIRQ_IRDY 31
`define SIRQ_PCIE_PM 32
`define SIRQ_UNUSED 33
`define SIRQ_ACL 34
`define SIRQ_REW 35
`define SIRQ_DDR 36
`define SIRQ_CPU_LO 37
`define SIRQ_CPU_HI 46
`define SIRQ_FSER_LO 47
`define SIRQ_FSER_HI 66
`define SIRQ_MSER_LO 67
`define SIRQ_MSER_HI 79
`define SIRQ_PORT_LO 80
`define SIRQ_PORT_HI 144
`define SIRQ_ECC 145
`define SIRQ_AXI_ERR 146
`define SIRQ_LEG_D 147
`define SIRQ_LEG_C 148
`define SIRQ_LEG_B 149
`define SIRQ_LEG_A 150
`define SIRQ_RC_SYS 151
`define SIRQ_RC_PME 152
`define SIRQ_RC_AER 153
`define SIRQ_RC_SII 154
`define SIRQ_RC_WAKE 155

// message interrupt translation register byte offset and widths
`define SIRQ_MSG_ADDR_W 16
`define SIRQ_MSG_DATA_W 32
`define SIRQ_XLATE_OFS 16'h0040

`endif

/* hw/sirq_msg_xlate.v */
// message interrupt capture on writes to the translation register
`timescale 1ns/1ps
`default_nettype none
`include "sirq_defines.vh"

module sirq_msg_xlate #(
    parameter AW = `SIRQ_MSG_ADDR_W,
    parameter DW = `SIRQ_MSG_DATA_W
) (
    input wire clk,
    input wire rst,
    input wire wr_en,
    input wire [AW-1:0] wr_addr,
    input wire [DW-1:0] wr_data,
    output reg irq_valid_reg,
    output reg [DW-1:0] irq_id_reg
);

    wire hit;
    localparam [AW-1:0] XLATE_OFS = `SIRQ_XLATE_OFS;

    // only a write that lands on the translation register raises an event
    assign hit = wr_en && (wr_addr == XLATE_OFS);

    ////////////////////////////////////////////////////////////////////////
    // one-cycle event pulse, identifier held until the next event
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            irq_valid_reg <= 1'h0;
            irq_id_reg <= {DW{1'h0}};
        end
        else
        begin
            irq_valid_reg <= hit;
            if (hit)
            begin
                irq_id_reg <= wr_data; // written data names the interrupt
            end
        end
    end

endmodule // sirq_msg_xlate

`default_nettype wire

/* test/sirq_map_checker.sv */
// assertions on the shared interrupt vector and the message interrupt path
`timescale 1ns/1ps
`default_nettype none
`include "sirq_defines.vh"
module sirq_map_checker #(
    parameter N_MGMT = 4,
    parameter N_FSER = 20
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic serial_port_irq_zero,
    input wire logic serial_port_irq_one,
    input wire logic two_wire_ctrl_irq_zero,
    input wire logic two_wire_ctrl_irq_one,
    input wire logic [N_MGMT-1:0] mgmt_master_irqs,
    input wire logic [N_FSER-1:0] fast_serializer_irqs,
    input wire logic cache_ecc_fatal_irq,
    input wire logic bus_external_error_irq,
    input wire logic pcie_legacy_line_a,
    input wire logic pcie_legacy_line_b,
    input wire logic pcie_legacy_line_c,
    input wire logic pcie_legacy_line_d,
    input wire logic msg_wr_en,
    input wire logic [`SIRQ_MSG_ADDR_W-1:0] msg_wr_addr,
    input wire logic [`SIRQ_MSG_DATA_W-1:0] msg_wr_data,
    input wire logic [`SIRQ_SPI_W-1:0] spi_vec_reg,
    input wire logic msg_irq_valid,
    input wire logic [`SIRQ_MSG_DATA_W-1:0] msg_irq_id
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////
    // a write that hits the translation register, and its one-cycle answer
    sequence s_hit;
        msg_wr_en && (msg_wr_addr == `SIRQ_XLATE_OFS);
    endsequence
    sequence s_pulse;
        msg_irq_valid && (msg_irq_id == $past(msg_wr_data));
    endsequence
    // vector bits follow their sources one cycle late; no history right after reset
    a_uart_pair: assert property (!$past(rst) |->
        spi_vec_reg[10:9] == {$past(serial_port_irq_one), $past(serial_port_irq_zero)})
        else $error("serial port interrupt misplaced");
    a_two_wire: assert property (!$past(rst) |->
        spi_vec_reg[12:11] == {$past(two_wire_ctrl_irq_one), $past(two_wire_ctrl_irq_zero)})
        else $error("two-wire interrupt misplaced");
    a_mgmt_order: assert property (!$past(rst) |-> spi_vec_reg[24:21] == $past(mgmt_master_irqs))
        else $error("management interrupts misplaced");
    a_fast_ser: assert property (!$past(rst) |-> spi_vec_reg[66:47] == $past(fast_serializer_irqs))
        else $error("fast serializer interrupts misplaced");
    a_cache_ecc_fatal_irq: assert property (!$past(rst) |->
        spi_vec_reg[146:145] == {$past(bus_external_error_irq), $past(cache_ecc_fatal_irq)})
        else $error("processor error interrupts misplaced");
    a_legacy_rev: assert property (!$past(rst) |-> spi_vec_reg[150:147] ==
        {$past(pcie_legacy_line_a), $past(pcie_legacy_line_b), $past(pcie_legacy_line_c), $past(pcie_legacy_line_d)})
        else $error("legacy lines misplaced");
    a_spare_low: assert property (spi_vec_reg[2] == 1'h0 && spi_vec_reg[33] == 1'h0)
        else $error("unassigned input active");
    a_msg_pulse: assert property (s_hit |=> s_pulse)
        else $error("message interrupt missing");
    a_msg_quiet: assert property (!(msg_wr_en && msg_wr_addr == `SIRQ_XLATE_OFS) |=> !msg_irq_valid)
        else $error("message interrupt without a hit");
    a_id_held: assert property (!(msg_wr_en && msg_wr_addr == `SIRQ_XLATE_OFS) |=> $stable(msg_irq_id))
        else $error("message id changed without a hit");
endmodule // sirq_map_checker

bind sirq_shared_map sirq_map_checker #(.N_MGMT(N_MGMT), .N_FSER(N_FSER)) u_chk (
    .clk, .rst, .serial_port_irq_zero, .serial_port_irq_one, .two_wire_ctrl_irq_zero, .two_wire_ctrl_irq_one,
    .mgmt_master_irqs, .fast_serializer_irqs, .cache_ecc_fatal_irq, .bus_external_error_irq,
    .pcie_legacy_line_a, .pcie_legacy_line_b, .pcie_legacy_line_c, .pcie_legacy_line_d,
    .msg_wr_en, .msg_wr_addr, .msg_wr_data, .spi_vec_reg, .msg_irq_valid, .msg_irq_id
);
`default_nettype wire

/* test/sirq_gic_model.sv */
// receiving side of the message interrupts: counts deliveries, keeps the last id
`timescale 1ns/1ps
`default_nettype none
`include "sirq_defines.vh"
module sirq_gic_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic msg_irq_valid,
    input wire logic [`SIRQ_MSG_DATA_W-1:0] msg_irq_id,
    output logic [7:0] lpi_count_reg,
    output logic [`SIRQ_MSG_DATA_W-1:0] lpi_last_reg
);
    // each one-cycle pulse is one delivered message interrupt, no wire per source
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            lpi_count_reg <= 8'h00;
            lpi_last_reg <= '0;
        end
        else if (msg_irq_valid)
        begin
            lpi_count_reg <= lpi_count_reg + 8'h01;
            lpi_last_reg <= msg_irq_id;
        end
    end
endmodule // sirq_gic_model
`default_nettype wire

/* test/sirq_shared_map_bench.sv */
// self-checking bench for the shared interrupt map
`timescale 1ns/1ps
`default_nettype none
`include "sirq_defines.vh"
module sirq_shared_map_bench;
    logic clk;
    logic rst;
    logic [155:0] src;
    logic msg_wr_en;
    logic [15:0] msg_wr_addr;
    logic [31:0] msg_wr_data;
    wire [155:0] spi;
    wire msg_irq_valid;
    wire [31:0] msg_irq_id;
    wire [7:0] lpi_count;
    wire [31:0] lpi_last;
    int err_count;
    int total_checks;
    localparam logic [155:0] SPARE = (156'h1 << 2) | (156'h1 << 33);
    ////////////////////////////////////////////////////////////////
    // every source is one bit of src at the index it should land on
    sirq_shared_map dut (
        .clk(clk), .rst(rst), .pin_mapped_irq_zero(src[0]), .pin_mapped_irq_one(src[1]),
        .storage_wake_irq(src[3]), .storage_irq(src[4]), .watchdog_irq(src[5]), .timer_irqs(src[8:6]),
        .serial_port_irq_zero(src[9]), .serial_port_irq_one(src[10]), .two_wire_ctrl_irq_zero(src[11]),
        .two_wire_ctrl_irq_one(src[12]), .serial_master_ctrl_irq(src[13]), .aux_processor_lock_irq(src[14]),
        .mailbox_soft_irq_zero(src[15]), .mailbox_soft_irq_one(src[16]), .serial_pin_expander_irqs(src[19:17]),
        .parallel_pin_irq(src[20]), .mgmt_master_irqs(src[24:21]), .frame_dma_irq(src[25]),
        .frame_analyzer_irq(src[26]), .timestamp_ready_irq(src[27]), .time_sync_irq(src[28]),
        .mem_integrity_irq(src[29]), .extraction_ready_irq(src[30]), .injection_ready_irq(src[31]),
        .pcie_power_mgmt_irq(src[32]), .access_list_irq(src[34]), .rewriter_irq(src[35]), .ddr_ctrl_irq(src[36]),
        .cpu_shared_irqs(src[46:37]), .fast_serializer_irqs(src[66:47]), .mid_serializer_irqs(src[79:67]),
        .port_module_irqs(src[144:80]), .cache_ecc_fatal_irq(src[145]), .bus_external_error_irq(src[146]),
        .pcie_legacy_line_d(src[147]), .pcie_legacy_line_c(src[148]), .pcie_legacy_line_b(src[149]),
        .pcie_legacy_line_a(src[150]), .root_complex_system_error(src[151]), .root_complex_pme(src[152]),
        .root_complex_adv_error(src[153]), .root_complex_sii(src[154]), .root_complex_wake(src[155]),
        .msg_wr_en(msg_wr_en), .msg_wr_addr(msg_wr_addr), .msg_wr_data(msg_wr_data),
        .spi_vec_reg(spi), .msg_irq_valid(msg_irq_valid), .msg_irq_id(msg_irq_id)
    );
    sirq_gic_model u_gic (.clk(clk), .rst(rst), .msg_irq_valid(msg_irq_valid), .msg_irq_id(msg_irq_id),
        .lpi_count_reg(lpi_count), .lpi_last_reg(lpi_last));
    // 200 MHz clock
    initial
    begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end
    task automatic chk(input logic [155:0] seen, input logic [155:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
            err_count++;
        end
    endtask
    task automatic results();
        if (err_count == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // walking one, then alternating and all-ones, a new pattern every cycle
    task automatic t_map();
        for (int i = 0; i < 158; i++)
        begin
            src = (i < 156) ? (156'h1 << i) : ((i == 156) ? {39{4'ha}} : {156{1'h1}});
            @(negedge clk);
            chk(spi[16:0], src[16:0] & ~SPARE[16:0]);
            chk(spi[46:17], src[46:17] & ~SPARE[46:17]);
            chk(spi[79:47], src[79:47]);
            chk(spi[155:80], src[155:80]);
        end
    endtask
    // reset in mid-run with every source high, then the first edge after release
    task automatic t_reset();
        src = {156{1'h1}};
        @(negedge clk);
        rst = 1'h1;
        #1;
        chk(spi, 156'h0);
        chk(msg_irq_valid, 1'h0);
        chk(msg_irq_id, 32'h0);
        @(negedge clk);
        rst = 1'h0;
        @(negedge clk);
        chk(spi, ~SPARE);
        src = '0;
    endtask
    // back-to-back hits, misses at nearby addresses, an address match without strobe
    task automatic t_msg();
        logic hit;
        logic [31:0] last;
        last = 32'h0;
        for (int i = 0; i < 7; i++)
        begin
            msg_wr_en = (i != 3) && (i != 6);
            msg_wr_addr = (i == 2) ? 16'h0044 : ((i == 4) ? 16'h0041 : `SIRQ_XLATE_OFS);
            msg_wr_data = 32'hc0de_0000 + i;
            hit = msg_wr_en && (msg_wr_addr == `SIRQ_XLATE_OFS);
            if (hit) last = msg_wr_data;
            @(negedge clk);
            chk(msg_irq_valid, hit);
            chk(msg_irq_id, last);
        end
        chk(lpi_count, 8'h03);
        chk(lpi_last, 32'hc0de_0005);
    endtask
    // watchdog against a hang
    initial
    begin
        #20000;
        err_count++;
        results();
    end
    // main sequence
    initial
    begin
        rst = 1'h1;
        src = '0;
        msg_wr_en = 1'h0;
        msg_wr_addr = 16'h0;
        msg_wr_data = 32'h0;
        err_count = 0;
        total_checks = 0;
        repeat (3) @(negedge clk);
        rst = 1'h0;
        t_map();
        t_msg();
        t_reset();
        results();
    end
endmodule // sirq_shared_map_bench
`default_nettype wire
